// ---- gdfs_pkg.sv ----
// constants and types for the power-stage fault status register bank
//Contract
//- 32-bit read-only power-stage status register at E0h, resets to zero.
//- bit 31 reads the OR of all individual driver fault bits.
//- bit 30 reads 1 while a step-down regulator fault is present.
//- bit 28 reads 1 when the overcurrent flag or any switch overcurrent is detected (step-down overcurrent goes to bit 30).
//- bit 27 reads 0 when motor-supply power-on reset is detected, else 1.
//- bit 26 reads 1 while motor-supply overvoltage is detected.
//- bit 25 reads 1 when thermal warning or thermal shutdown is detected.
//- bit 23 reads 1 while thermal warning is detected.
//- bit 22 reads 1 while thermal shutdown is detected.
//- bits 21..16 flag switch overcurrent, C high first down to A low.
//- bit 14 reads 1 while a one-time-programmable memory error is detected.
//- bit 13 reads 1 while step-down regulator overcurrent is detected.
//- bit 12 reads 1 while step-down regulator undervoltage is detected.
//- bit 11 reads 1 while charge pump undervoltage is detected.
//- read-only controller fault status register exists at E2h.
package gdfs_pkg;

	// register addresses on the status port
	localparam logic [7:0] GDFS_ADDR_POWER = 8'hE0;
	localparam logic [7:0] GDFS_ADDR_CTRL = 8'hE2;

	// reset values
	localparam logic [31:0] GDFS_RESET_WORD = 32'h0000_0000;

	// field positions in the power-stage word
	localparam int GDFS_POS_SUMMARY = 31;
	localparam int GDFS_POS_STEPDOWN = 30;
	localparam int GDFS_POS_OVERCUR = 28;
	localparam int GDFS_POS_POR_N = 27;
	localparam int GDFS_POS_OVERVOLT = 26;
	localparam int GDFS_POS_THERMAL = 25;
	localparam int GDFS_POS_WARN = 23;
	localparam int GDFS_POS_SHUTDOWN = 22;
	localparam int GDFS_POS_SWITCH_LO = 16;
	localparam int GDFS_POS_OTP = 14;
	localparam int GDFS_POS_SD_OVERCUR = 13;
	localparam int GDFS_POS_SD_UNDERV = 12;
	localparam int GDFS_POS_PUMP_UV = 11;

	// individual fault bits gathered into the summary, and reserved bits
	localparam logic [31:0] GDFS_FAULT_MASK = 32'h56FF_7800;
	localparam logic [31:0] GDFS_RSVD_MASK = 32'h2100_87FF;

	// index of each detector condition in the sampled vector
	localparam int GDFS_COND_W = 16;
	localparam int GDFS_C_SWITCH_LO = 0;
	localparam int GDFS_C_OVERCUR = 6;
	localparam int GDFS_C_POR = 7;
	localparam int GDFS_C_OVERVOLT = 8;
	localparam int GDFS_C_WARN = 9;
	localparam int GDFS_C_SHUTDOWN = 10;
	localparam int GDFS_C_OTP = 11;
	localparam int GDFS_C_SD_OVERCUR = 12;
	localparam int GDFS_C_SD_UNDERV = 13;
	localparam int GDFS_C_PUMP_UV = 14;
	localparam int GDFS_C_STEPDOWN = 15;

	// status port sequencer states
	typedef enum logic [1:0] {
		GDFS_IDLE = 2'b01,
		GDFS_ANSWER = 2'b10
	} gdfs_state_type;

endpackage

// ---- gdfs_cond_sampler.sv ----
// per-bit sampling flops for the detector condition inputs
`timescale 1ns/1ps
`default_nettype none
module gdfs_cond_sampler
	import gdfs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [GDFS_COND_W-1:0] cond_i,
	output logic [GDFS_COND_W-1:0] sampled_o
);

	// one flop per detector, refreshed every clock
	genvar gi;
	generate
		for (gi = 0; gi < GDFS_COND_W; gi++)
		begin : g_bit
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					sampled_o[gi] <= 1'b0;
				else
					sampled_o[gi] <= cond_i[gi];
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ---- gdfs_word_pack.sv ----
// packs the sampled conditions into the power-stage status word
`timescale 1ns/1ps
`default_nettype none
module gdfs_word_pack
	import gdfs_pkg::*;
(
	input wire logic [GDFS_COND_W-1:0] sampled_i,
	output logic [31:0] word_o
);

	logic [31:0] fields;

	// individual fields; reserved bits stay zero
	always_comb
	begin
		fields = GDFS_RESET_WORD;
		fields[GDFS_POS_STEPDOWN] = sampled_i[GDFS_C_STEPDOWN] | sampled_i[GDFS_C_SD_OVERCUR]
			| sampled_i[GDFS_C_SD_UNDERV];
		fields[GDFS_POS_OVERCUR] = sampled_i[GDFS_C_OVERCUR] | (|sampled_i[GDFS_C_SWITCH_LO +: 6]);
		fields[GDFS_POS_POR_N] = ~sampled_i[GDFS_C_POR];
		fields[GDFS_POS_OVERVOLT] = sampled_i[GDFS_C_OVERVOLT];
		fields[GDFS_POS_THERMAL] = sampled_i[GDFS_C_WARN] | sampled_i[GDFS_C_SHUTDOWN];
		fields[GDFS_POS_WARN] = sampled_i[GDFS_C_WARN];
		fields[GDFS_POS_SHUTDOWN] = sampled_i[GDFS_C_SHUTDOWN];
		fields[GDFS_POS_SWITCH_LO +: 6] = sampled_i[GDFS_C_SWITCH_LO +: 6];
		fields[GDFS_POS_OTP] = sampled_i[GDFS_C_OTP];
		fields[GDFS_POS_SD_OVERCUR] = sampled_i[GDFS_C_SD_OVERCUR];
		fields[GDFS_POS_SD_UNDERV] = sampled_i[GDFS_C_SD_UNDERV];
		fields[GDFS_POS_PUMP_UV] = sampled_i[GDFS_C_PUMP_UV];
	end

	// summary over the individual fault bits, recomputed every cycle
	always_comb
	begin
		word_o = fields;
		word_o[GDFS_POS_SUMMARY] = |(fields & GDFS_FAULT_MASK);
	end

endmodule
`default_nettype wire

// ---- gdfs_fault_status.sv ----
// power-stage and controller fault status registers with their read port
`timescale 1ns/1ps
`default_nettype none
module gdfs_fault_status
	import gdfs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// detector condition inputs, active high
	input wire logic stepdown_regulator_fault_i,
	input wire logic overcurrent_flag_i,
	input wire logic motor_supply_reset_i,
	input wire logic supply_overvoltage_flag_i,
	input wire logic thermal_warning_flag_i,
	input wire logic thermal_shutdown_flag_i,
	input wire logic phase_c_high_overcurrent_i,
	input wire logic phase_c_low_overcurrent_i,
	input wire logic phase_b_high_overcurrent_i,
	input wire logic phase_b_low_overcurrent_i,
	input wire logic phase_a_high_overcurrent_i,
	input wire logic phase_a_low_overcurrent_i,
	input wire logic otp_error_i,
	input wire logic stepdown_overcurrent_flag_i,
	input wire logic stepdown_undervoltage_flag_i,
	input wire logic pump_undervoltage_flag_i,
	// controller fault word from the control core
	input wire logic [31:0] controller_fault_i,
	// status register port
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic driver_fault_o
);

	logic [GDFS_COND_W-1:0] cond;
	logic [GDFS_COND_W-1:0] sampled;
	logic [31:0] next_power_word;
	logic [31:0] power_stage_fault_flags;
	logic [31:0] controller_fault_flags;
	gdfs_state_type state;
	gdfs_state_type next_state;
	logic request;
	logic [31:0] next_rdata;

	// gather detector inputs into one vector
	assign cond[GDFS_C_SWITCH_LO +: 6] = {phase_c_high_overcurrent_i, phase_c_low_overcurrent_i,
		phase_b_high_overcurrent_i, phase_b_low_overcurrent_i,
		phase_a_high_overcurrent_i, phase_a_low_overcurrent_i};
	assign cond[GDFS_C_OVERCUR] = overcurrent_flag_i;
	assign cond[GDFS_C_POR] = motor_supply_reset_i;
	assign cond[GDFS_C_OVERVOLT] = supply_overvoltage_flag_i;
	assign cond[GDFS_C_WARN] = thermal_warning_flag_i;
	assign cond[GDFS_C_SHUTDOWN] = thermal_shutdown_flag_i;
	assign cond[GDFS_C_OTP] = otp_error_i;
	assign cond[GDFS_C_SD_OVERCUR] = stepdown_overcurrent_flag_i;
	assign cond[GDFS_C_SD_UNDERV] = stepdown_undervoltage_flag_i;
	assign cond[GDFS_C_PUMP_UV] = pump_undervoltage_flag_i;
	assign cond[GDFS_C_STEPDOWN] = stepdown_regulator_fault_i;

	// sample the detectors on the system clock
	gdfs_cond_sampler u_sampler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(cond),
		.sampled_o(sampled)
	);

	// build the status word from the sampled conditions
	gdfs_word_pack u_pack (
		.sampled_i(sampled),
		.word_o(next_power_word)
	);

	// power-stage register, read only, written by hardware each cycle
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			power_stage_fault_flags <= GDFS_RESET_WORD;
		else
			power_stage_fault_flags <= next_power_word;
	end

	// controller register, refreshed from the control core
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			controller_fault_flags <= GDFS_RESET_WORD;
		else
			controller_fault_flags <= controller_fault_i;
	end

	// summary output for a fault pin
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			driver_fault_o <= 1'b0;
		else
			driver_fault_o <= next_power_word[GDFS_POS_SUMMARY];
	end

	// a read or a write is taken only while idle
	assign request = (reg_rd_i | reg_wr_i) && (state == GDFS_IDLE);

	// port sequencer
	always_comb
	begin
		next_state = state;
		unique case (state)
			GDFS_IDLE:
			begin
				if (request)
					next_state = GDFS_ANSWER;
			end
			GDFS_ANSWER:
			begin
				next_state = GDFS_IDLE;
			end
			default:
			begin
				next_state = GDFS_IDLE;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state <= GDFS_IDLE;
		else
			state <= next_state;
	end

	// read data: reserved addresses and writes return zero
	always_comb
	begin
		next_rdata = GDFS_RESET_WORD;
		if (reg_rd_i)
		begin
			if (reg_addr_i == GDFS_ADDR_POWER)
				next_rdata = power_stage_fault_flags;
			else if (reg_addr_i == GDFS_ADDR_CTRL)
				next_rdata = controller_fault_flags;
		end
	end

	// answer one cycle after the request; writes are acknowledged and dropped
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reg_ack_o <= 1'b0;
			reg_rdata_o <= GDFS_RESET_WORD;
		end
		else
		begin
			reg_ack_o <= request;
			if (request)
				reg_rdata_o <= next_rdata;
		end
	end

	// checks on the status word and the port
	// field checks skip attempts that start in reset, while the pipeline still holds zeros

	chk_summary_or: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_SUMMARY] ==
		$past((|cond[GDFS_C_POR-1:0]) | (|cond[GDFS_COND_W-1:GDFS_C_POR+1]), 2)))
		else $error("summary bit differs from OR of fault inputs");

	chk_fault_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		driver_fault_o == power_stage_fault_flags[GDFS_POS_SUMMARY])
		else $error("fault pin differs from summary bit");

	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_stage_fault_flags & GDFS_RSVD_MASK) == 32'h0000_0000)
		else $error("reserved status bit set");

	chk_stepdown_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && stepdown_regulator_fault_i) |-> ##2 power_stage_fault_flags[GDFS_POS_STEPDOWN])
		else $error("step-down fault not reported");

	chk_stepdown_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !stepdown_regulator_fault_i && !stepdown_overcurrent_flag_i && !stepdown_undervoltage_flag_i)
		|-> ##2 !power_stage_fault_flags[GDFS_POS_STEPDOWN])
		else $error("step-down bit set with no step-down fault");

	chk_overcurrent_all: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && (overcurrent_flag_i || (|cond[GDFS_C_SWITCH_LO +: 6]))) |-> ##2 power_stage_fault_flags[GDFS_POS_OVERCUR])
		else $error("overall overcurrent not reported");

	chk_overcurrent_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !overcurrent_flag_i && !(|cond[GDFS_C_SWITCH_LO +: 6]))
		|-> ##2 !power_stage_fault_flags[GDFS_POS_OVERCUR])
		else $error("overall overcurrent set with no overcurrent");

	chk_por_invert: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_POR_N] == !$past(motor_supply_reset_i, 2)))
		else $error("supply reset bit polarity wrong");

	chk_por_release: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |=> power_stage_fault_flags[GDFS_POS_POR_N])
		else $error("supply reset bit not high after reset");

	chk_overvolt_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_OVERVOLT] == $past(supply_overvoltage_flag_i, 2)))
		else $error("overvoltage bit does not follow detector");

	chk_thermal_join: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_THERMAL] ==
		$past(thermal_warning_flag_i | thermal_shutdown_flag_i, 2)))
		else $error("thermal bit is not warning or shutdown");

	chk_warn_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && $rose(thermal_warning_flag_i)) |-> ##2 power_stage_fault_flags[GDFS_POS_WARN])
		else $error("thermal warning not reported");

	chk_warn_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && $fell(thermal_warning_flag_i)) |-> ##2 !power_stage_fault_flags[GDFS_POS_WARN])
		else $error("thermal warning bit did not clear");

	chk_shutdown_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_SHUTDOWN] == $past(thermal_shutdown_flag_i, 2)))
		else $error("thermal shutdown bit does not follow detector");

	chk_switch_order: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_SWITCH_LO +: 6] == $past(cond[GDFS_C_SWITCH_LO +: 6], 2)))
		else $error("switch overcurrent bits misplaced");

	chk_otp_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_OTP] == $past(otp_error_i, 2)))
		else $error("memory error bit does not follow detector");

	chk_sd_overcurrent: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_SD_OVERCUR] == $past(stepdown_overcurrent_flag_i, 2)))
		else $error("step-down overcurrent bit wrong");

	chk_sd_undervolt: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_SD_UNDERV] == $past(stepdown_undervoltage_flag_i, 2)))
		else $error("step-down undervoltage bit wrong");

	chk_pump_uv: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##2 (power_stage_fault_flags[GDFS_POS_PUMP_UV] == $past(pump_undervoltage_flag_i, 2)))
		else $error("charge pump undervoltage bit wrong");

	chk_reset_word: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |->
		(power_stage_fault_flags == GDFS_RESET_WORD && controller_fault_flags == GDFS_RESET_WORD))
		else $error("status register not zero after reset");

	chk_pins_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (!driver_fault_o && !reg_ack_o && reg_rdata_o == GDFS_RESET_WORD))
		else $error("port outputs not zero after reset");

	// port checks
	chk_power_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && reg_rd_i && reg_addr_i == GDFS_ADDR_POWER) |=>
		(reg_ack_o && reg_rdata_o == $past(power_stage_fault_flags)))
		else $error("power-stage read returned wrong word");

	chk_ctrl_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && reg_rd_i && reg_addr_i == GDFS_ADDR_CTRL) |=>
		(reg_ack_o && reg_rdata_o == $past(controller_fault_flags)))
		else $error("controller read returned wrong word");

	chk_ctrl_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |-> ##1 (controller_fault_flags == $past(controller_fault_i)))
		else $error("controller register does not follow its input");

	chk_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && !reg_rd_i) |=> (reg_ack_o && reg_rdata_o == 32'h0000_0000))
		else $error("write changed read data");

	chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && reg_rd_i && reg_addr_i != GDFS_ADDR_POWER && reg_addr_i != GDFS_ADDR_CTRL) |=>
		(reg_ack_o && reg_rdata_o == GDFS_RESET_WORD))
		else $error("unlisted address returned data");

	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_ack_o |=> !reg_ack_o)
		else $error("acknowledge held longer than one cycle");

	chk_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_ack_o |-> $past(request))
		else $error("acknowledge without a taken request");

	chk_busy_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == GDFS_ANSWER && (reg_rd_i || reg_wr_i)) |=> !reg_ack_o)
		else $error("request during answer cycle was taken");

	chk_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !$past(rst_i) && !$past(request)) |-> $stable(reg_rdata_o))
		else $error("read data changed without a request");

	chk_answer_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == GDFS_ANSWER) |=> (state == GDFS_IDLE))
		else $error("sequencer stayed in answer cycle");

	chk_state_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot(state))
		else $error("sequencer state not one-hot");

endmodule
`default_nettype wire

// ---- gdfs_host_model.sv ----
// host model that reads and writes the status register port
`timescale 1ns/1ps
`default_nettype none
module gdfs_host_model
	import gdfs_pkg::*;
(
	input wire logic clk_i,
	input wire logic reg_ack_i,
	input wire logic [31:0] reg_rdata_i,
	output logic reg_rd_o,
	output logic reg_wr_o,
	output logic [7:0] reg_addr_o
);
	// port idle from time zero
	initial
	begin
		reg_rd_o = 1'b0;
		reg_wr_o = 1'b0;
		reg_addr_o = 8'h00;
	end

	// one access: raise after an edge, hold until ack is sampled high or 8 edges pass, take data on ack and release there
	task automatic access(input logic wr, input logic [7:0] addr, output logic [31:0] data, output logic ok);
		int n;
		ok = 1'b0;
		data = 32'h0000_0000;
		@(posedge clk_i);
		reg_rd_o <= ~wr;
		reg_wr_o <= wr;
		reg_addr_o <= addr;
		for (n = 0; n < 8 && !ok; n++)
		begin
			@(posedge clk_i);
			if (reg_ack_i === 1'b1)
			begin
				ok = 1'b1;
				data = reg_rdata_i;
			end
		end
		reg_rd_o <= 1'b0;
		reg_wr_o <= 1'b0;
	endtask

	// read any address
	task automatic read_reg(input logic [7:0] addr, output logic [31:0] data, output logic ok);
		access(1'b0, addr, data, ok);
	endtask

	// writes go only to the two listed registers, reserved places are left alone
	task automatic write_reg(input logic [7:0] addr, output logic [31:0] data, output logic ok);
		data = 32'h0000_0000;
		ok = 1'b0;
		if (addr === GDFS_ADDR_POWER || addr === GDFS_ADDR_CTRL)
			access(1'b1, addr, data, ok);
	endtask
endmodule
`default_nettype wire

// ---- gdfs_fault_status_test.sv ----
// self-checking bench for the fault status register bank
`timescale 1ns/1ps
`default_nettype none
module gdfs_fault_status_test
	import gdfs_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] cond = 16'h0000;
	logic [31:0] ctrl_word = 32'h0000_0000;
	wire logic reg_rd;
	wire logic reg_wr;
	wire logic [7:0] reg_addr;
	wire logic [31:0] reg_rdata;
	wire logic reg_ack;
	wire logic driver_fault;
	logic [31:0] data;
	logic ok;
	int n_errors = 0;
	int n_compared = 0;
	// expected word for each single detector, supply-reset bit left out
	localparam logic [31:0] exp_one [16] = '{32'hC000_0000, 32'h9000_0000, 32'h0000_0000, 32'h8400_0000,
		32'h8280_0000, 32'h8240_0000, 32'h9020_0000, 32'h9010_0000, 32'h9008_0000, 32'h9004_0000,
		32'h9002_0000, 32'h9001_0000, 32'h8000_4000, 32'hC000_2000, 32'hC000_1000, 32'h8000_0800};
	localparam logic [7:0] unmapped [4] = '{8'hE1, 8'hE3, 8'hE4, 8'h00};

	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;

	gdfs_fault_status DUT (.clk_i(clk_i), .rst_i(rst_i),
		.stepdown_regulator_fault_i(cond[0]), .overcurrent_flag_i(cond[1]), .motor_supply_reset_i(cond[2]),
		.supply_overvoltage_flag_i(cond[3]), .thermal_warning_flag_i(cond[4]), .thermal_shutdown_flag_i(cond[5]),
		.phase_c_high_overcurrent_i(cond[6]), .phase_c_low_overcurrent_i(cond[7]),
		.phase_b_high_overcurrent_i(cond[8]), .phase_b_low_overcurrent_i(cond[9]),
		.phase_a_high_overcurrent_i(cond[10]), .phase_a_low_overcurrent_i(cond[11]), .otp_error_i(cond[12]),
		.stepdown_overcurrent_flag_i(cond[13]), .stepdown_undervoltage_flag_i(cond[14]),
		.pump_undervoltage_flag_i(cond[15]), .controller_fault_i(ctrl_word), .reg_rd_i(reg_rd),
		.reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_rdata_o(reg_rdata), .reg_ack_o(reg_ack),
		.driver_fault_o(driver_fault));

	gdfs_host_model host (.clk_i(clk_i), .reg_ack_i(reg_ack), .reg_rdata_i(reg_rdata), .reg_rd_o(reg_rd),
		.reg_wr_o(reg_wr), .reg_addr_o(reg_addr));

	// compare a 32-bit result
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	// compare a one-bit result
	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	// read one address and compare acknowledge and data
	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
		host.read_reg(addr, data, ok);
		check_bit(ok, 1'b1);
		check_word(data, exp);
	endtask

	// let detector changes reach the status word
	task automatic settle();
		repeat (3) @(posedge clk_i);
	endtask

	// counts and verdict
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		check_word(reg_rdata, 32'h0000_0000);
		check_bit(driver_fault, 1'b0);
		rst_i <= 1'b0;
		settle();
		rd_chk(GDFS_ADDR_POWER, 32'h0800_0000);
		// one detector at a time, the previous one cleared
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk_i);
			cond <= 16'h0001 << i;
			settle();
			@(negedge clk_i);
			check_bit(driver_fault, exp_one[i][31]);
			rd_chk(GDFS_ADDR_POWER, exp_one[i] | (i == 2 ? 32'h0 : 32'h0800_0000));
		end
		@(posedge clk_i);
		cond <= 16'hFFFF;
		settle();
		rd_chk(GDFS_ADDR_POWER, 32'hD6FF_7800);
		host.write_reg(GDFS_ADDR_POWER, data, ok);
		check_bit(ok, 1'b1);
		check_word(data, 32'h0000_0000);
		rd_chk(GDFS_ADDR_POWER, 32'hD6FF_7800);
		foreach (unmapped[k])
			rd_chk(unmapped[k], 32'h0000_0000);
		@(posedge clk_i);
		ctrl_word <= 32'hA5C3_0F1E;
		settle();
		rd_chk(GDFS_ADDR_CTRL, 32'hA5C3_0F1E);
		host.write_reg(GDFS_ADDR_CTRL, data, ok);
		rd_chk(GDFS_ADDR_CTRL, 32'hA5C3_0F1E);
		@(posedge clk_i);
		cond <= 16'h0000;
		settle();
		rd_chk(GDFS_ADDR_POWER, 32'h0800_0000);
		// reset in mid-run with every detector but the supply reset active
		@(posedge clk_i);
		cond <= 16'hFFFB;
		settle();
		rst_i <= 1'b1;
		@(negedge clk_i);
		check_word(reg_rdata, 32'h0000_0000);
		check_bit(driver_fault, 1'b0);
		@(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		rd_chk(GDFS_ADDR_POWER, 32'hDEFF_7800);
		close_out();
	end

	// watchdog well beyond the expected run length
	initial
	begin
		#20000;
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
endmodule
`default_nettype wire
